//--- hdl/keypad_pkg.sv
package keypad_pkg;

    localparam int          LINE_COUNT          = 8;

    // Register addresses on the special function register port
    localparam logic [7:0]  LEVEL_SELECT_ADDR   = 8'h9C;
    localparam logic [7:0]  LINE_ENABLE_ADDR    = 8'h9D;
    localparam logic [7:0]  LINE_FLAGS_ADDR     = 8'h9E;

    // Reset values
    localparam logic [7:0]  LEVEL_SELECT_RESET  = 8'h00;
    localparam logic [7:0]  LINE_ENABLE_RESET   = 8'h00;
    localparam logic        LINE_FLAG_RESET     = 1'b0;
    localparam logic [7:0]  READ_DATA_RESET     = 8'h00;

    // Unmapped addresses read back as this value
    localparam logic [7:0]  UNMAPPED_READ_VALUE = 8'h00;

    // Level-select encoding
    localparam logic        DETECT_LOW          = 1'b0;
    localparam logic        DETECT_HIGH         = 1'b1;

endpackage

//--- hdl/keypad_line_detect.sv
`timescale 1ns/1ps

module keypad_line_detect
    import keypad_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic pinLevel,
    input  wire logic levelSelect,
    input  wire logic lineEnable,
    input  wire logic readClear,
    output logic      flag,
    output logic      irqTerm
);

    logic levelHit;
    logic next_flag;

    always_comb begin
        // Level compare, no edge: a held key keeps re-setting the flag
        levelHit  = (pinLevel == levelSelect);                      // see R1 R5
        // Set wins over the read clear
        next_flag = (flag & ~readClear) | levelHit;                 // see R3 R10
        irqTerm   = flag & lineEnable;                              // see R2 R4
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag <= LINE_FLAG_RESET;                                // see R6
        end else begin
            flag <= next_flag;
        end
    end

endmodule

//--- hdl/keypad_level_interrupt.sv
// Function
// R1: Programmed level on line sets its flag
// R2: Flag requests interrupt only when line enabled
// R3: Flag register read-only; read clears all flags
// R4: Enable zero: plain pin, one: interrupt allowed
// R5: Level select zero low, one high
// R6: All three registers reset to zero
// R7: Eight lines share one interrupt request
// R8: Global enable gates combined keypad request
// R9: Enabled detection wakes from idle, power-down
// R10: Detection during read-clear keeps flag set
`timescale 1ns/1ps

module keypad_level_interrupt
    import keypad_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] keypadInputPort,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    input  wire logic       keypadGlobalIrqEnable,
    output logic            keypadIrq,
    output logic            wakeRequest
);

    logic [7:0] keypadLevelSelect;
    logic [7:0] keypadLineEnable;
    logic [7:0] keypadLineFlags;
    logic [7:0] irqTerms;
    logic [7:0] next_keypadLevelSelect;
    logic [7:0] next_keypadLineEnable;
    logic [7:0] next_sfrRdata;
    logic       readFlags;
    logic [7:0] levelMatch;

    assign readFlags  = sfrRead && (sfrAddr == LINE_FLAGS_ADDR);            // see R3
    assign levelMatch = ~(keypadInputPort ^ keypadLevelSelect);

    genvar i;
    generate
        for (i = 0; i < LINE_COUNT; i++) begin : gLine
            keypad_line_detect uLine (
                .core_clk    (core_clk),
                .rst_b       (rst_b),
                .pinLevel    (keypadInputPort[i]),
                .levelSelect (keypadLevelSelect[i]),
                .lineEnable  (keypadLineEnable[i]),
                .readClear   (readFlags),
                .flag        (keypadLineFlags[i]),
                .irqTerm     (irqTerms[i])
            );
        end
    endgenerate

    // Combinational so the request drops the same cycle software masks it
    assign keypadIrq   = keypadGlobalIrqEnable & (|irqTerms);              // see R7 R8
    // Wake ignores the global enable: the core may be stopped with it off
    assign wakeRequest = |irqTerms;                                         // see R9

    always_comb begin
        next_keypadLevelSelect = keypadLevelSelect;
        next_keypadLineEnable  = keypadLineEnable;
        next_sfrRdata          = sfrRdata;
        if (sfrWrite) begin
            case (sfrAddr)
                LEVEL_SELECT_ADDR: next_keypadLevelSelect = sfrWdata;       // see R5
                LINE_ENABLE_ADDR:  next_keypadLineEnable  = sfrWdata;       // see R4
                // Flag register ignores writes
                default:           ;                                        // see R3
            endcase
        end
        if (sfrRead) begin
            case (sfrAddr)
                LEVEL_SELECT_ADDR: next_sfrRdata = keypadLevelSelect;
                LINE_ENABLE_ADDR:  next_sfrRdata = keypadLineEnable;
                LINE_FLAGS_ADDR:   next_sfrRdata = keypadLineFlags;         // see R3
                default:           next_sfrRdata = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            keypadLevelSelect <= LEVEL_SELECT_RESET;                        // see R6
            keypadLineEnable  <= LINE_ENABLE_RESET;                         // see R6
            sfrRdata          <= READ_DATA_RESET;
        end else begin
            keypadLevelSelect <= next_keypadLevelSelect;
            keypadLineEnable  <= next_keypadLineEnable;
            sfrRdata          <= next_sfrRdata;
        end
    end

    property p_flag_set;
        @(posedge core_clk) disable iff (!rst_b)
        (levelMatch != 8'h00) |=> ((keypadLineFlags & $past(levelMatch)) == $past(levelMatch));
    endproperty
    a_flag_set: assert property (p_flag_set) // see R1
        else $error("matched line flag not set");

    property p_no_spurious_set;
        @(posedge core_clk) disable iff (!rst_b)
        (readFlags && levelMatch == 8'h00) |=> (keypadLineFlags == 8'h00);
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set) // see R5
        else $error("flag set without match");

    property p_masked_no_irq;
        @(posedge core_clk) disable iff (!rst_b)
        ((keypadLineFlags & keypadLineEnable) == 8'h00) |-> (!keypadIrq && !wakeRequest);
    endproperty
    a_masked_no_irq: assert property (p_masked_no_irq) // see R2
        else $error("irq from masked flag");

    property p_read_clear;
        @(posedge core_clk) disable iff (!rst_b)
        readFlags |=> (sfrRdata == $past(keypadLineFlags))
                      && (keypadLineFlags == ($past(levelMatch) & 8'hFF));
    endproperty
    a_read_clear: assert property (p_read_clear) // see R3
        else $error("flag read or clear wrong");

    property p_write_ignored;
        @(posedge core_clk) disable iff (!rst_b)
        (sfrWrite && !sfrRead && sfrAddr == LINE_FLAGS_ADDR)
            |=> ((keypadLineFlags & $past(keypadLineFlags)) == $past(keypadLineFlags));
    endproperty
    a_write_ignored: assert property (p_write_ignored) // see R3
        else $error("write changed flags");

    property p_enable_write;
        @(posedge core_clk) disable iff (!rst_b)
        (sfrWrite && sfrAddr == LINE_ENABLE_ADDR) |=> (keypadLineEnable == $past(sfrWdata));
    endproperty
    a_enable_write: assert property (p_enable_write) // see R4
        else $error("enable write lost");

    property p_reset_values;
        @(posedge core_clk)
        !rst_b |=> (keypadLevelSelect == 8'h00 && keypadLineEnable == 8'h00
                    && keypadLineFlags == 8'h00 && !keypadIrq);
    endproperty
    a_reset_values: assert property (p_reset_values) // see R6
        else $error("reset values wrong");

    property p_shared_irq;
        @(posedge core_clk) disable iff (!rst_b)
        (keypadGlobalIrqEnable && (keypadLineFlags & keypadLineEnable) != 8'h00) |-> keypadIrq;
    endproperty
    a_shared_irq: assert property (p_shared_irq) // see R7
        else $error("enabled flag gave no irq");

    property p_global_gate;
        @(posedge core_clk) disable iff (!rst_b)
        !keypadGlobalIrqEnable |-> !keypadIrq;
    endproperty
    a_global_gate: assert property (p_global_gate) // see R8
        else $error("irq with global enable off");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_b)
        ((levelMatch & keypadLineEnable) != 8'h00 && !(sfrWrite && sfrAddr == LINE_ENABLE_ADDR))
            |=> wakeRequest [*2];
    endproperty
    a_wake: assert property (p_wake) // see R9
        else $error("enabled detection did not wake");

    property p_set_wins;
        @(posedge core_clk) disable iff (!rst_b)
        (readFlags && levelMatch != 8'h00)
            |=> ((keypadLineFlags & $past(levelMatch)) == $past(levelMatch));
    endproperty
    a_set_wins: assert property (p_set_wins) // see R10
        else $error("clear beat detection");

    property p_select_write;
        @(posedge core_clk) disable iff (!rst_b)
        (sfrWrite && sfrAddr == LEVEL_SELECT_ADDR) |=> (keypadLevelSelect == $past(sfrWdata));
    endproperty
    a_select_write: assert property (p_select_write) // see R5
        else $error("level select write lost");

    property p_select_read;
        @(posedge core_clk) disable iff (!rst_b)
        (sfrRead && sfrAddr == LEVEL_SELECT_ADDR)
            |=> (sfrRdata == $past(keypadLevelSelect));
    endproperty
    a_select_read: assert property (p_select_read) // see R5
        else $error("level select read wrong");

    property p_enable_read;
        @(posedge core_clk) disable iff (!rst_b)
        (sfrRead && sfrAddr == LINE_ENABLE_ADDR)
            |=> (sfrRdata == $past(keypadLineEnable));
    endproperty
    a_enable_read: assert property (p_enable_read) // see R4
        else $error("line enable read wrong");

    // Read data must stand between reads, the core may fetch it late
    property p_rdata_stands;
        @(posedge core_clk) disable iff (!rst_b)
        !sfrRead |=> $stable(sfrRdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) // see R3
        else $error("read data moved without a read");

    // Sticky: only a flags read may drop a flag
    property p_flag_hold;
        @(posedge core_clk) disable iff (!rst_b)
        !readFlags
            |=> ((keypadLineFlags & $past(keypadLineFlags)) == $past(keypadLineFlags));
    endproperty
    a_flag_hold: assert property (p_flag_hold) // see R3
        else $error("flag dropped without read");

    property p_flag_only_match;
        @(posedge core_clk) disable iff (!rst_b)
        rst_b
            |=> ((keypadLineFlags & ~$past(keypadLineFlags) & ~$past(levelMatch)) == 8'h00);
    endproperty
    a_flag_only_match: assert property (p_flag_only_match) // see R1
        else $error("flag rose without its match");

    property p_wake_source;
        @(posedge core_clk) disable iff (!rst_b)
        wakeRequest |-> ((keypadLineFlags & keypadLineEnable) != 8'h00);
    endproperty
    a_wake_source: assert property (p_wake_source) // see R9
        else $error("wake without enabled flag");

    c_irq_rise:   cover property (@(posedge core_clk) disable iff (!rst_b) $rose(keypadIrq));
    c_read_clear: cover property (@(posedge core_clk) disable iff (!rst_b)
        readFlags && keypadLineFlags != 8'h00 ##1 keypadLineFlags == 8'h00);
    c_set_wins:   cover property (@(posedge core_clk) disable iff (!rst_b)
        readFlags && levelMatch != 8'h00 ##1 keypadLineFlags != 8'h00);
    c_wake:       cover property (@(posedge core_clk) disable iff (!rst_b) $rose(wakeRequest));
    c_high_level: cover property (@(posedge core_clk) disable iff (!rst_b)
                                  keypadLevelSelect != 8'h00 ##1 keypadLineFlags != 8'h00);

endmodule

//--- bench/keypad_switch_model.sv
`timescale 1ns/1ps

module keypad_switch_model (
    input  wire logic [7:0] pressMask,
    input  wire logic [7:0] pressLevel,
    output logic      [7:0] lineLevel
);
    // Released keys rest at the opposite level, so a stale match cannot hide
    assign lineLevel = ~(pressMask ^ pressLevel);
endmodule

//--- bench/keypad_level_interrupt_tb.sv
`timescale 1ns/1ps

module keypad_level_interrupt_tb;
    import keypad_pkg::*;
    logic       core_clk              = 1'b0;
    logic       rst_b                 = 1'b0;
    logic [7:0] sfrAddr               = 8'h00;
    logic       sfrWrite              = 1'b0;
    logic       sfrRead               = 1'b0;
    logic [7:0] sfrWdata              = 8'h00;
    logic       keypadGlobalIrqEnable = 1'b0;
    logic [7:0] pressMask             = 8'h00;
    logic [7:0] pressLevel            = 8'h00;
    logic [7:0] keypadInputPort;
    logic [7:0] sfrRdata;
    logic       keypadIrq;
    logic       wakeRequest;
    logic [7:0] rd;
    int         num_errors            = 0;
    int         num_checks            = 0;

    always #2.5 core_clk = ~core_clk;

    keypad_switch_model MATRIX (.pressMask(pressMask), .pressLevel(pressLevel),
                                .lineLevel(keypadInputPort));

    keypad_level_interrupt DUT (.core_clk(core_clk), .rst_b(rst_b),
        .keypadInputPort(keypadInputPort), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .keypadGlobalIrqEnable(keypadGlobalIrqEnable), .keypadIrq(keypadIrq),
        .wakeRequest(wakeRequest));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfrAddr  <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge core_clk);
        sfrWrite <= 1'b0;
    endtask

    // Read data lands one edge after the strobe edge
    task automatic rdreg(input logic [7:0] a);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge core_clk);
        sfrRead <= 1'b0;
        #1 rd = sfrRdata;
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        rdreg(LEVEL_SELECT_ADDR);
        check(rd, 8'h00, "select reset");
        rdreg(LINE_ENABLE_ADDR);
        check(rd, 8'h00, "enable reset");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h00, "flags reset");
        wr(LINE_FLAGS_ADDR, 8'hFF);
        wr(8'h9F, 8'hFF);
        rdreg(8'h9F);
        check(rd, UNMAPPED_READ_VALUE, "unmapped read");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h00, "flags write ignored");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                wr(LEVEL_SELECT_ADDR, p ? 8'hFF : 8'h00);
                pressLevel <= p ? 8'hFF : 8'h00;
                wr(LINE_ENABLE_ADDR, ~(8'h01 << i));
                pressMask             <= 8'h01 << i;
                keypadGlobalIrqEnable <= 1'b1;
                repeat (2) @(posedge core_clk);
                #1 check({6'h00, keypadIrq, wakeRequest}, 8'h00, "masked line");
                wr(LINE_ENABLE_ADDR, 8'h01 << i);
                pressMask <= 8'h00;
                #1 check({6'h00, keypadIrq, wakeRequest}, 8'h03, "enabled line");
                @(posedge core_clk);
                keypadGlobalIrqEnable <= 1'b0;
                #1 check({6'h00, keypadIrq, wakeRequest}, 8'h01, "global off");
                rdreg(LINE_FLAGS_ADDR);
                check(rd, 8'h01 << i, "flag set");
                rdreg(LINE_FLAGS_ADDR);
                check(rd, 8'h00, "flag cleared");
            end
        end
        wr(LINE_ENABLE_ADDR, 8'h01);
        pressMask <= 8'h01;
        repeat (2) @(posedge core_clk);
        rdreg(LINE_FLAGS_ADDR);
        check({7'h00, wakeRequest}, 8'h01, "set beats clear");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h01, "match beats clear");
        @(posedge core_clk);
        pressMask <= 8'h00;
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h01, "held after release");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h00, "cleared after release");
        check({7'h00, wakeRequest}, 8'h00, "wake after clear");
        wr(LEVEL_SELECT_ADDR, 8'h5A);
        rdreg(LEVEL_SELECT_ADDR);
        check(rd, 8'h5A, "select readback");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'hA5, "mixed levels");
        rdreg(LINE_ENABLE_ADDR);
        check(rd, 8'h01, "enable readback");
        @(posedge core_clk);
        keypadGlobalIrqEnable <= 1'b1;
        pressLevel            <= 8'h00;
        rst_b                 <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        #1 check({6'h00, keypadIrq, wakeRequest}, 8'h00, "irq after reset");
        check(sfrRdata, READ_DATA_RESET, "read data reset");
        rdreg(LEVEL_SELECT_ADDR);
        check(rd, 8'h00, "select mid-run reset");
        rdreg(LINE_ENABLE_ADDR);
        check(rd, 8'h00, "enable mid-run reset");
        rdreg(LINE_FLAGS_ADDR);
        check(rd, 8'h00, "flags mid-run reset");
        report_and_stop();
    end
endmodule
